//--- hdl/reset_strap_capture.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "strap_map.svh"
module reset_strap_capture
    import strap_pkg::*;
#(
    parameter int MD_W = 44
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             sys_reset_n,
    input  wire logic [MD_W-1:0]  memory_data_lines,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    output logic                  isa_low_mem_write_strobe,
    output logic                  pci_clock_div3,
    output hclk_sel_type          host_clock_sel,
    output logic                  core_clock_double,
    output logic                  straps_valid
);
    logic [MD_W-1:0] md_sync;       // filtered strap lines
    logic            rst_sync;      // filtered system reset level
    logic [7:0]      low_q;         // dram low banks register
    logic [7:0]      high_q;        // dram high banks register
    logic [7:0]      misc_q;        // misc clock strap register
    logic [7:0]      pll_q;         // host pll strap register
    logic            core_q;        // core multiplier strap
    cap_state_type   state_q;       // capture sequencer
    logic            acc_wr;        // register write strobe
    logic [7:0]      acc_idx;       // register index
    logic [7:0]      acc_wbyte;     // write data byte
    logic [7:0]      rd_byte;       // selected read byte
    logic            rd_hit;        // index maps to a register

    // strap lines and system reset come from pins
    pin_sync3 #(.W(MD_W + 1)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .pin_in  ({sys_reset_n, memory_data_lines}),
        .pin_out ({rst_sync, md_sync})
    );

    apb_slave u_apb (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pstrb     (pstrb),
        .rd_byte   (rd_byte),
        .rd_hit    (rd_hit),
        .acc_wr    (acc_wr),
        .acc_idx   (acc_idx),
        .acc_wbyte (acc_wbyte),
        .pready    (pready),
        .pslverr   (pslverr),
        .prdata    (prdata)
    );

    // sequencer: sample while system reset low, hold after
    // sample then hold
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_SAMPLE;
        end else if (clk_en) begin
            unique case (state_q)
                ST_SAMPLE: if (rst_sync) state_q <= ST_HELD;
                ST_HELD:   if (!rst_sync) state_q <= ST_SAMPLE;
                // unused codes fall back to sampling
                default:   state_q <= ST_SAMPLE;
            endcase
        end
    end

    // low and high dram banks: plain mirrors of lines 15..0
    // low and high bank capture
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            low_q  <= `STRAP_RST;
            high_q <= `STRAP_RST;
        end else if (clk_en && state_q == ST_SAMPLE) begin
            low_q  <= md_sync[7:0];
            high_q <= md_sync[15:8];
        end
    end

    // misc register: capture, then software may write bit 4
    // misc capture
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            misc_q <= `STRAP_RST;
        end else if (clk_en) begin
            if (state_q == ST_SAMPLE) begin
                misc_q <= {2'b00, md_sync[`LINE_MISC23],
                           md_sync[`LINE_MISC_LSB +: 5]};
            end else if (acc_wr && acc_idx == `IDX_MISC_CLOCK) begin
                misc_q[`MISC_WR_BIT] <= acc_wbyte[`MISC_WR_BIT];
            end
        end
    end

    // pll register mirrors lines 26..21, core strap line 40
    // pll capture
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pll_q  <= `STRAP_RST;
            core_q <= 1'b0;
        end else if (clk_en && state_q == ST_SAMPLE) begin
            pll_q  <= {2'b00, md_sync[26:21]};
            core_q <= md_sync[`LINE_CORE_MUL];
        end
    end

    // read mux; of the dram bits only low bit 0 feeds anything else (the pin function output)
    // read only
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (acc_idx)
            `IDX_DRAM_LOW:   rd_byte = low_q;
            `IDX_DRAM_HIGH:  rd_byte = high_q;
            `IDX_MISC_CLOCK: rd_byte = misc_q;
            `IDX_HOST_PLL:   rd_byte = pll_q;
            default:         rd_hit  = 1'b0;
        endcase
    end

    // function selects, registered outputs
    // pin function
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            isa_low_mem_write_strobe <= 1'b0;
            pci_clock_div3           <= 1'b0;
            host_clock_sel           <= HCLK_25;
            core_clock_double        <= 1'b0;
            straps_valid             <= 1'b0;
        end else if (clk_en) begin
            isa_low_mem_write_strobe <= low_q[`LOW_PIN_FN_BIT];
            pci_clock_div3           <= misc_q[`MISC_PCI_DIV_BIT];
            host_clock_sel  <= hclk_sel_type'(pll_q[`PLL_LSB +: 3]);
            core_clock_double        <= core_q;
            straps_valid             <= (state_q == ST_HELD);
        end
    end
endmodule : reset_strap_capture

//--- hdl/strap_map.svh
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH
// register indexes as printed; byte address is four times the index
`define IDX_DRAM_LOW        8'h4A
`define IDX_DRAM_HIGH       8'h4B
`define IDX_MISC_CLOCK      8'h4C
`define IDX_HOST_PLL        8'h5F
// field positions
`define MISC_WR_BIT         4
`define MISC_PCI_DIV_BIT    1
`define MISC_LINE23_BIT     5
`define LOW_PIN_FN_BIT      0
`define PLL_LSB             3
// strap line positions on the memory data bus
`define LINE_MISC_LSB       16
`define LINE_MISC23         23
`define LINE_PLL_LSB        24
`define LINE_CORE_MUL       40
// reset values before capture
`define STRAP_RST           8'h00
`endif

//--- hdl/strap_pkg.sv
package strap_pkg;
    // capture sequencer states
    typedef enum logic [1:0] {ST_SAMPLE, ST_HELD} cap_state_type;
    // host clock selection codes
    typedef enum logic [2:0] {
        HCLK_25, HCLK_33, HCLK_40, HCLK_50,
        HCLK_60, HCLK_66, HCLK_75, HCLK_80
    } hclk_sel_type;
endpackage : strap_pkg

//--- hdl/pin_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; change accepted once stages 2 and 3 agree
module pin_sync3 #(
    parameter int W = 44
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_q;   // metastable stage
    logic [W-1:0] s2_q;   // second stage
    logic [W-1:0] s3_q;   // third stage

    // shift chain
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (clk_en) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    pin_out[i] <= 1'b0;
                end else if (clk_en && (s2_q[i] == s3_q[i])) begin
                    pin_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync3

//--- hdl/apb_slave.sv
`timescale 1ns/1ps
// minimal one-wait apb slave front end
module apb_slave (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [7:0]  rd_byte,
    input  wire logic        rd_hit,
    output logic             acc_wr,
    output logic [7:0]       acc_idx,
    output logic [7:0]       acc_wbyte,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata
);
    logic acc_q;   // access phase accepted last cycle
    logic addr_ok; // aligned word inside the decoded window

    // upper address bits must be clear so registers do not alias
    assign addr_ok = rd_hit && (paddr[1:0] == 2'h0)
                     && (paddr[11:10] == 2'h0);

    // index from byte address
    assign acc_idx   = paddr[9:2];
    assign acc_wbyte = pwdata[7:0];
    // write fires at the edge ending the first access cycle, before pready, lane 0 only
    assign acc_wr    = psel && penable && pwrite && pstrb[0] && !acc_q
                       && clk_en && addr_ok;

    // one wait state: pready rises the cycle after access begins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_q   <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (psel && penable && !acc_q) begin
                acc_q   <= 1'b1;
                pready  <= 1'b1;
                pslverr <= !addr_ok;
                prdata  <= (pwrite || !addr_ok) ? 32'h0000_0000
                                               : {24'h000000, rd_byte};
            end else begin
                acc_q   <= 1'b0;
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end
endmodule : apb_slave

//--- sim/strap_monitor.sv
`timescale 1ns/1ps
`include "strap_map.svh"
// watches the apb answer and the strap outputs of the capture block
module strap_monitor
    import strap_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic [31:0]  prdata,
    input wire logic         isa_low_mem_write_strobe,
    input wire logic         pci_clock_div3,
    input wire hclk_sel_type host_clock_sel,
    input wire logic         core_clock_double,
    input wire logic         straps_valid
);
    // byte addresses of the strap registers
    localparam logic [11:0] A_LO = {2'b00, `IDX_DRAM_LOW, 2'b00};
    localparam logic [11:0] A_HI = {2'b00, `IDX_DRAM_HIGH, 2'b00};
    localparam logic [11:0] A_MI = {2'b00, `IDX_MISC_CLOCK, 2'b00};
    localparam logic [11:0] A_PL = {2'b00, `IDX_HOST_PLL, 2'b00};
    logic hit; // access to a mapped register
    logic rd;  // read answer with straps held
    assign hit = paddr inside {A_LO, A_HI, A_MI, A_PL};
    assign rd  = pready && !pwrite && straps_valid;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("answer not after one wait state");
    a_pulse_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (psel && penable && !pready && !hit
        |=> pslverr) else $error("unmapped access not refused");
    a_wr_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("write answer not zero");
    a_pin_fn: assert property (rd && paddr == A_LO
        |-> prdata[0] == isa_low_mem_write_strobe) else $error("pin fn");
    a_pci_div: assert property (rd && paddr == A_MI
        |-> prdata[1] == pci_clock_div3) else $error("pci divisor");
    a_host_sel: assert property (rd && paddr == A_PL
        |-> prdata[5:3] == host_clock_sel) else $error("host clock sel");
    a_held_stable: assert property (straps_valid && $past(straps_valid)
        && $past(straps_valid, 2) |-> $stable(host_clock_sel)
        && $stable(core_clock_double) && $stable(pci_clock_div3))
        else $error("held strap output moved");
endmodule : strap_monitor

bind reset_strap_capture strap_monitor u_strap_monitor (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .prdata, .isa_low_mem_write_strobe, .pci_clock_div3,
    .host_clock_sel, .core_clock_double, .straps_valid
);

//--- sim/board_straps.sv
`timescale 1ns/1ps
// board resistors on the data lines, then memory traffic after reset
module board_straps (
    input  wire logic        clk_sys,
    input  wire logic        bus_active,
    input  wire logic [43:0] user_straps,
    output logic      [43:0] memory_data_lines
);
    localparam logic [43:0] PULL_UP   = 44'h4F000FD4948;
    localparam logic [43:0] PULL_DOWN = 44'hA0FF8000000;
    logic [43:0] noise_q = 44'h0; // traffic, changes every cycle
    // johnson pattern stands for memory cycles
    always_ff @(posedge clk_sys) begin
        noise_q <= {noise_q[42:0], ~noise_q[43]};
    end
    assign memory_data_lines = bus_active ? noise_q
                             : (user_straps & ~PULL_DOWN) | PULL_UP;
endmodule : board_straps

//--- sim/tb.sv
`timescale 1ns/1ps
`include "strap_map.svh"
// captures straps eight times and reads them back over apb
module tb;
    import strap_pkg::*;
    localparam logic [11:0] ADR [4] = '{{2'b00, `IDX_DRAM_LOW, 2'b00},
        {2'b00, `IDX_DRAM_HIGH, 2'b00}, {2'b00, `IDX_MISC_CLOCK, 2'b00},
        {2'b00, `IDX_HOST_PLL, 2'b00}};
    logic         clk_sys     = 1'b0;
    logic         rst_n       = 1'b0;
    logic         sys_reset_n = 1'b0;
    logic         bus_active  = 1'b0;
    logic         psel        = 1'b0;
    logic         penable     = 1'b0;
    logic         pwrite      = 1'b0;
    logic [11:0]  paddr       = 12'h000;
    logic [31:0]  pwdata      = 32'h0;
    logic [43:0]  user_straps = 44'h0;
    logic [31:0]  rng         = 32'hB63ED8E1; // xorshift state
    logic         pready, pslverr, isa, div3, core, valid, e;
    logic [31:0]  prdata, r;
    logic [43:0]  memory_data_lines, s;
    hclk_sel_type hsel;
    logic [7:0]   ex [4];     // expected register contents
    int           miscompares = 0;
    int           n_tests     = 0;
    // clock of 4 ns
    always #2 clk_sys = ~clk_sys;
    reset_strap_capture u_reset_strap_capture (.clk_sys, .rst_n,
        .clk_en(1'b1), .sys_reset_n, .memory_data_lines, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .pslverr, .prdata,
        .isa_low_mem_write_strobe(isa), .pci_clock_div3(div3),
        .host_clock_sel(hsel), .core_clock_double(core),
        .straps_valid(valid));
    board_straps u_board_straps (.clk_sys, .bus_active, .user_straps,
        .memory_data_lines);
    // next pseudo-random word
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    // register layout expected from the captured lines
    function automatic logic [7:0] exp_reg(input logic [43:0] v, input int k);
        case (k)
            0: return v[7:0];
            1: return v[15:8];
            2: return {2'b00, v[23], v[20:16]};
            default: return {2'b00, v[26:21]};
        endcase
    endfunction : exp_reg
    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            summarize();
        end
        q = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // read all four registers against ex, as software does
    task automatic rdall();
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ADR[k], 32'h0, r, e);
            chk("reg", r, {24'h0, ex[k]});
            chk("err", 32'(e), 32'h0);
        end
    endtask : rdall
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            user_straps <= {r[11:0], 5'(r >> 12), 3'(i), 24'(rnd())};
            sys_reset_n <= 1'b0;
            bus_active  <= 1'b0;
            repeat (8) @(posedge clk_sys);
            s = memory_data_lines;
            sys_reset_n <= 1'b1;
            repeat (8) @(posedge clk_sys);
            bus_active <= 1'b1;
            chk("valid", 32'(valid), 32'h1);
            chk("isa", 32'(isa), 32'(s[0]));
            chk("div3", 32'(div3), 32'(s[17]));
            chk("hsel", 32'(hsel), 32'(i));
            chk("core", 32'(core), 32'(s[40]));
            for (int k = 0; k < 4; k++) ex[k] = exp_reg(s, k);
            rdall();
            for (int k = 0; k < 4; k++) begin
                apb(1'b1, ADR[k], rnd(), r, e);
                if (k == 2) ex[2][4] = pwdata[4];
            end
            rdall();
            apb(1'b0, 12'h200, 32'h0, r, e);
            chk("unmapped", 32'(e), 32'h1);
            apb(1'b0, ADR[i % 4] + 12'h1, 32'h0, r, e);
            chk("misaligned", 32'(e), 32'h1);
        end
        summarize();
    end
endmodule : tb
